// File: aicirq_regs.svh
// Register offsets, command codes, field positions and reset values of the interrupt logic
`ifndef AICIRQ_REGS_SVH
`define AICIRQ_REGS_SVH

// ----------------------------------------------------------------
// Register addresses on the host bus
// ----------------------------------------------------------------
`define AICIRQ_ADDR_CMD        4'h0
`define AICIRQ_ADDR_IRQ_ENABLE 4'h2
`define AICIRQ_ADDR_IRQ_STATUS 4'h2
`define AICIRQ_ADDR_DATA       4'h6

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define AICIRQ_CMD_INTERP_MODE 8'h2A
`define AICIRQ_CMD_INTERP_CLR  8'h6F
`define AICIRQ_CMD_SEG_FIRST   8'h30
`define AICIRQ_CMD_SEG_LAST    8'h3F

// ----------------------------------------------------------------
// Field positions and levels
// ----------------------------------------------------------------
`define AICIRQ_BIT_PREBUF_LOW  14
`define AICIRQ_BIT_PREBUF_MID  15
`define AICIRQ_PREBUF_LOW_FROM 4'h4
`define AICIRQ_PREBUF_LOW_TO   4'h3
`define AICIRQ_PREBUF_MID_FROM 4'h8
`define AICIRQ_PREBUF_MID_TO   4'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AICIRQ_RST_IRQ_ENABLE  16'h0000
`define AICIRQ_RST_IRQ_STATUS  16'h0000

`endif

// File: aicirq_pkg.sv
// Shared types of the axis and interpolation interrupt logic
`default_nettype none
package aicirq_pkg;
   typedef logic [15:0] aicirq_word_t;
   typedef logic [1:0]  aicirq_byte_en_t;
   typedef logic [1:0]  aicirq_axis_idx_t;
   typedef logic [3:0]  aicirq_addr_t;
endpackage : aicirq_pkg
`default_nettype wire

// File: aicirq_axis_if.sv
// Link between the bus front end and one axis interrupt unit
`timescale 1ns/1ps
`default_nettype none
interface aicirq_axis_if;
   logic                      en_wr;
   aicirq_pkg::aicirq_byte_en_t be;
   aicirq_pkg::aicirq_word_t    wdata;
   logic                      rd_clr;
   aicirq_pkg::aicirq_word_t    status;
   logic                      pending;

   modport front (output en_wr, be, wdata, rd_clr, input status, pending);
   modport axis  (input en_wr, be, wdata, rd_clr, output status, pending);
endinterface : aicirq_axis_if
`default_nettype wire

// File: aicirq_axis.sv
// One axis: interrupt enable word and read-to-clear status word
`timescale 1ns/1ps
`default_nettype none
`include "aicirq_regs.svh"
module aicirq_axis #(
   parameter int WIDTH = 16
) (
   input  wire logic             mclk_i,
   input  wire logic             rstn_i,
   input  wire logic [WIDTH-1:0] factor_i,
   aicirq_axis_if.axis           bus
);
   logic [WIDTH-1:0] enable_q;
   logic [WIDTH-1:0] factor_q;
   logic [WIDTH-1:0] status_q;
   logic [WIDTH-1:0] status_d;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] set;
   logic [WIDTH-1:0] clr_mask;

   if (WIDTH != 16) begin : g_width_chk
      $error("aicirq_axis supports a 16-bit word only");
   end

   // ----------------------------------------------------------------
   // Enable word
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         enable_q <= `AICIRQ_RST_IRQ_ENABLE;
      end else if (bus.en_wr) begin
         if (bus.be[0]) begin
            enable_q[7:0] <= bus.wdata[7:0];
         end
         if (bus.be[1]) begin
            enable_q[15:8] <= bus.wdata[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         factor_q <= '0;
      end else begin
         factor_q <= factor_i;
      end
   end

   // Bits 0-3 compare hits, 4-9 drive and timer events, 10-11 split, 12-15 sync
   assign rise = factor_i & ~factor_q;
   assign set  = rise & enable_q;

   always_comb begin
      clr_mask = '0;
      if (bus.rd_clr) begin
         clr_mask = {{8{bus.be[1]}}, {8{bus.be[0]}}};
      end
      // A fresh event in the clearing cycle survives
      status_d = (status_q & ~clr_mask) | set;
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_q <= `AICIRQ_RST_IRQ_STATUS;
      end else begin
         status_q <= status_d;
      end
   end

   assign bus.status  = status_q;
   assign bus.pending = |status_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   status_set_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (|set) |=> ((status_q & $past(set)) == $past(set)))
      else $error("enabled event did not set its status bit");
   blocked_event_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      1'b1 |=> ((status_q & ~$past(status_q) & ~$past(enable_q)) == '0))
      else $error("disabled event set a status bit");
   read_clear_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (bus.rd_clr && bus.be == 2'b11 && set == '0) |=> (status_q == '0))
      else $error("status read did not clear the word");
   byte_clear_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (bus.rd_clr && bus.be == 2'b01 && set == '0)
      |=> (status_q[7:0] == 8'h00 && status_q[15:8] == $past(status_q[15:8])))
      else $error("low byte read touched the high byte");
   set_wins_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (bus.rd_clr && (|set)) |=> ((status_q & $past(set)) != '0))
      else $error("event lost on clearing read");
endmodule : aicirq_axis
`default_nettype wire

// File: aicirq_top.sv
// Axis and interpolation interrupt logic with its host bus front end
// Summary of operation
// - Status bits 0-3 flag a new compare hit of compare registers 0-3.
// - Bits 4-9: drive start, const-speed start/end, drive end, home end, timer.
// - Bit 10 flags each split pulse rise, bit 11 split train done.
// - Bits 12-15 flag synchronous actions 0-3 firing.
// - Enable bit 1 lets its event interrupt; 0 blocks it.
// - Enabled event sets its status bit and pulls axis interrupt low.
// - Reading status clears set bits and releases the axis interrupt.
// - Only the first read after an event reports it.
// - Further events before the read also set their bits.
// - 8-bit bus: byte-wise enables and clears; release once both bytes clear.
// - Serial bus: enables per byte or word; host reads both status bytes.
// - A completed serial status read clears bits and releases the line.
// - Interp mode command bits 14 and 15 set the interp interrupt enables.
// - Bit 14 fires on prebuffer 4 to 3, bit 15 on 8 to 7.
// - Enabled interp factor pulls the interp interrupt low.
// - Clear command, next segment command or interp end releases it.
// - Reset clears every interrupt enable.
`timescale 1ns/1ps
`default_nettype none
`include "aicirq_regs.svh"
module aicirq_top #(
   parameter int N_AXES = 4,
   parameter int WIDTH  = 16
) (
   input  wire logic                           mclk_i,
   input  wire logic                           rstn_i,
   input  wire logic                           read_strobe_n_i,
   input  wire logic                           write_strobe_n_i,
   input  wire aicirq_pkg::aicirq_addr_t       host_addr_i,
   input  wire aicirq_pkg::aicirq_byte_en_t    host_be_i,
   input  wire aicirq_pkg::aicirq_axis_idx_t   host_axis_i,
   input  wire aicirq_pkg::aicirq_word_t       host_wdata_i,
   input  wire logic [N_AXES*WIDTH-1:0]        axis_factor_i,
   input  wire logic [3:0]                     prebuf_count_i,
   input  wire logic                           cont_interp_busy_i,
   output logic [WIDTH-1:0]                    host_rdata_o,
   output logic                                axis_irq_n_o,
   output logic                                axis_irq_oe_o,
   output logic                                interp_irq_n_o,
   output logic                                interp_irq_oe_o
);
   if (N_AXES != 4 || WIDTH != 16) begin : g_cfg_chk
      $error("aicirq_top serves four axes of 16-bit words only");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int SW = 2 + 4 + 2 + 2 + 16;
   logic [SW-1:0] pin_meta_q;
   logic [SW-1:0] pin_sync_q;
   logic          rd_n_prev_q;
   logic          wr_n_prev_q;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_meta_q <= {2'b11, {(SW-2){1'b0}}};
         pin_sync_q <= {2'b11, {(SW-2){1'b0}}};
      end else begin
         pin_meta_q <= {read_strobe_n_i, write_strobe_n_i, host_addr_i,
                        host_be_i, host_axis_i, host_wdata_i};
         pin_sync_q <= pin_meta_q;
      end
   end

   logic                        rd_n_s;
   logic                        wr_n_s;
   aicirq_pkg::aicirq_addr_t    addr_s;
   aicirq_pkg::aicirq_byte_en_t be_s;
   aicirq_pkg::aicirq_axis_idx_t axis_s;
   aicirq_pkg::aicirq_word_t    wdata_s;

   assign {rd_n_s, wr_n_s, addr_s, be_s, axis_s, wdata_s} = pin_sync_q;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_n_prev_q <= 1'b1;
         wr_n_prev_q <= 1'b1;
      end else begin
         rd_n_prev_q <= rd_n_s;
         wr_n_prev_q <= wr_n_s;
      end
   end

   logic rd_start;
   logic rd_end;
   logic wr_end;

   assign rd_start = rd_n_prev_q & ~rd_n_s;
   // Clearing waits for the end of the strobe so a read is complete first
   assign rd_end   = ~rd_n_prev_q & rd_n_s;
   assign wr_end   = ~wr_n_prev_q & wr_n_s;

   // ----------------------------------------------------------------
   // Axis units
   // ----------------------------------------------------------------
   aicirq_axis_if ax_if [N_AXES] ();
   logic [N_AXES-1:0]    ax_pending;
   logic [WIDTH-1:0]     ax_status [N_AXES];
   logic                 status_hit;
   logic                 enable_hit;

   assign status_hit = (addr_s == `AICIRQ_ADDR_IRQ_STATUS);
   assign enable_hit = (addr_s == `AICIRQ_ADDR_IRQ_ENABLE);

   for (genvar g = 0; g < N_AXES; g++) begin : g_axis
      assign ax_if[g].en_wr  = wr_end && enable_hit && (axis_s == 2'(g));
      assign ax_if[g].be     = be_s;
      assign ax_if[g].wdata  = wdata_s;
      // Any read of this address clears; a wandering address can hit it too
      assign ax_if[g].rd_clr = rd_end && status_hit && (axis_s == 2'(g));
      assign ax_pending[g]   = ax_if[g].pending;
      assign ax_status[g]    = ax_if[g].status;

      aicirq_axis #(
         .WIDTH (WIDTH)
      ) u_axis (
         .mclk_i   (mclk_i),
         .rstn_i   (rstn_i),
         .factor_i (axis_factor_i[g*WIDTH +: WIDTH]),
         .bus      (ax_if[g])
      );
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Data is captured at the strobe start and held for the host
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         host_rdata_o <= 16'h0000;
      end else if (rd_start) begin
         if (status_hit) begin
            host_rdata_o <= ax_status[axis_s] & {{8{be_s[1]}}, {8{be_s[0]}}};
         end else begin
            host_rdata_o <= 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Axis interrupt line
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         axis_irq_n_o  <= 1'b0;
         axis_irq_oe_o <= 1'b0;
      end else begin
         axis_irq_n_o  <= 1'b0;
         axis_irq_oe_o <= |ax_pending;
      end
   end

   // ----------------------------------------------------------------
   // Command decode and interpolation interrupt
   // ----------------------------------------------------------------
   aicirq_pkg::aicirq_word_t data_q;
   logic                     low_en_q;
   logic                     mid_en_q;
   logic [3:0]               prebuf_prev_q;
   logic                     busy_prev_q;
   logic                     interp_pend_q;
   logic                     cmd_wr;
   logic [7:0]               cmd;
   logic                     low_hit;
   logic                     mid_hit;
   logic                     interp_set;
   logic                     interp_clr;

   assign cmd_wr = wr_end && (addr_s == `AICIRQ_ADDR_CMD);
   assign cmd    = wdata_s[7:0];

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_q <= 16'h0000;
      end else if (wr_end && addr_s == `AICIRQ_ADDR_DATA) begin
         data_q <= wdata_s;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         low_en_q <= 1'b0;
         mid_en_q <= 1'b0;
      end else if (cmd_wr && cmd == `AICIRQ_CMD_INTERP_MODE) begin
         low_en_q <= data_q[`AICIRQ_BIT_PREBUF_LOW];
         mid_en_q <= data_q[`AICIRQ_BIT_PREBUF_MID];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prebuf_prev_q <= 4'h0;
         busy_prev_q   <= 1'b0;
      end else begin
         prebuf_prev_q <= prebuf_count_i;
         busy_prev_q   <= cont_interp_busy_i;
      end
   end

   assign low_hit = (prebuf_prev_q == `AICIRQ_PREBUF_LOW_FROM)
                 && (prebuf_count_i == `AICIRQ_PREBUF_LOW_TO);
   assign mid_hit = (prebuf_prev_q == `AICIRQ_PREBUF_MID_FROM)
                 && (prebuf_count_i == `AICIRQ_PREBUF_MID_TO);
   assign interp_set = (low_hit && low_en_q) || (mid_hit && mid_en_q);
   assign interp_clr = (cmd_wr && cmd == `AICIRQ_CMD_INTERP_CLR)
                    || (cmd_wr && cmd >= `AICIRQ_CMD_SEG_FIRST
                               && cmd <= `AICIRQ_CMD_SEG_LAST)
                    || (busy_prev_q && !cont_interp_busy_i);

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         interp_pend_q <= 1'b0;
      end else if (interp_set) begin
         interp_pend_q <= 1'b1;
      end else if (interp_clr) begin
         interp_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         interp_irq_n_o  <= 1'b0;
         interp_irq_oe_o <= 1'b0;
      end else begin
         interp_irq_n_o  <= 1'b0;
         interp_irq_oe_o <= interp_pend_q;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence interp_hit_s;
      interp_set ##1 interp_pend_q;
   endsequence

   sequence line_low_s;
      interp_irq_oe_o && !interp_irq_n_o;
   endsequence

   axis_line_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (|ax_pending) |=> (axis_irq_oe_o && !axis_irq_n_o))
      else $error("axis line not driven low while pending");
   axis_release_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ax_pending == '0) |=> !axis_irq_oe_o)
      else $error("axis line driven with nothing pending");
   interp_drive_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      interp_hit_s |=> line_low_s)
      else $error("interp line not low after enabled factor");
   interp_hold_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (interp_pend_q && !interp_clr) |=> interp_pend_q)
      else $error("interp pending dropped without a clear");
   interp_clear_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (interp_clr && !interp_set) |=> !interp_pend_q ##1 !interp_irq_oe_o)
      else $error("interp line not released after clear");
   interp_block_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      $rose(interp_pend_q) |-> $past(low_hit && low_en_q || mid_hit && mid_en_q))
      else $error("interp pending without an enabled level drop");

   // ----------------------------------------------------------------
   // Command decode and foreign reads
   // ----------------------------------------------------------------
   // Each clear cause has its own check so a wrong code range shows by name
   logic mode_wr;

   assign mode_wr = cmd_wr && (cmd == `AICIRQ_CMD_INTERP_MODE);

   sequence clr_cmd_s;
      cmd_wr && (cmd == `AICIRQ_CMD_INTERP_CLR) && !interp_set;
   endsequence

   sequence seg_cmd_s;
      cmd_wr && (cmd >= `AICIRQ_CMD_SEG_FIRST) && (cmd <= `AICIRQ_CMD_SEG_LAST) && !interp_set;
   endsequence

   sequence busy_end_s;
      busy_prev_q && !cont_interp_busy_i && !interp_set;
   endsequence

   mode_load_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      mode_wr |=> (low_en_q == data_q[`AICIRQ_BIT_PREBUF_LOW]
                   && mid_en_q == data_q[`AICIRQ_BIT_PREBUF_MID]))
      else $error("interp enables not loaded by mode command");
   mode_hold_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      !mode_wr |=> ($stable(low_en_q) && $stable(mid_en_q)))
      else $error("interp enables changed without mode command");
   interp_off_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (!low_en_q && !mid_en_q && !interp_pend_q) |=> !interp_pend_q)
      else $error("interp pending with both enables off");
   clr_cmd_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      clr_cmd_s |=> !interp_pend_q)
      else $error("clear command did not release interp line");
   seg_cmd_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      seg_cmd_s |=> !interp_pend_q)
      else $error("segment command did not release interp line");
   busy_end_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      busy_end_s |=> !interp_pend_q ##1 !interp_irq_oe_o)
      else $error("interpolation end did not release interp line");
   other_read_a : assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (rd_end && !status_hit && (|ax_pending)) |=> (|ax_pending))
      else $error("read of another register cleared axis status");
endmodule : aicirq_top
`default_nettype wire

// File: aicirq_host_model.sv
// Host CPU model that runs register cycles on the strobe pins
`timescale 1ns/1ps
`default_nettype none
module aicirq_host_model (
   input  wire logic                         mclk_i,
   input  wire aicirq_pkg::aicirq_word_t     rdata_i,
   output var  logic                         read_strobe_n_o,
   output var  logic                         write_strobe_n_o,
   output var  aicirq_pkg::aicirq_addr_t     addr_o,
   output var  aicirq_pkg::aicirq_byte_en_t  be_o,
   output var  aicirq_pkg::aicirq_axis_idx_t axis_o,
   output var  aicirq_pkg::aicirq_word_t     wdata_o
);
   initial begin
      read_strobe_n_o  = 1'b1;
      write_strobe_n_o = 1'b1;
      addr_o           = 4'hf;
      be_o             = 2'b00;
      axis_o           = 2'b00;
      wdata_o          = 16'h0000;
   end

   // One bus cycle; slow stretches the strobe like a sluggish host
   task automatic access(input logic rd, input aicirq_pkg::aicirq_addr_t a,
                         input aicirq_pkg::aicirq_axis_idx_t ax,
                         input aicirq_pkg::aicirq_byte_en_t be,
                         input aicirq_pkg::aicirq_word_t d, input int slow,
                         output aicirq_pkg::aicirq_word_t q);
      addr_o  <= a;
      be_o    <= be;
      axis_o  <= ax;
      wdata_o <= d;
      @(posedge mclk_i);
      read_strobe_n_o  <= !rd;
      write_strobe_n_o <= rd;
      repeat (6 + slow) @(posedge mclk_i);
      q = rdata_i;
      read_strobe_n_o  <= 1'b1;
      write_strobe_n_o <= 1'b1;
      // Address held until the synchronised strobe end has used it
      repeat (4) @(posedge mclk_i);
      // Released pins show the inverse, never a stale match
      addr_o  <= ~a;
      be_o    <= ~be;
      axis_o  <= ~ax;
      wdata_o <= ~d;
      @(posedge mclk_i);
   endtask : access
endmodule : aicirq_host_model
`default_nettype wire

// File: axis_and_interp_irq_logic_tb.sv
// Self-checking bench for the axis and interpolation interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "aicirq_regs.svh"
module axis_and_interp_irq_logic_tb;
   logic                         mclk_i;
   logic                         rstn_i;
   logic                         rd_n;
   logic                         wr_n;
   aicirq_pkg::aicirq_addr_t     addr;
   aicirq_pkg::aicirq_byte_en_t  be;
   aicirq_pkg::aicirq_axis_idx_t axis;
   aicirq_pkg::aicirq_word_t     wdata;
   aicirq_pkg::aicirq_word_t     rdata;
   logic [63:0]                  factor;
   logic [3:0]                   prebuf;
   logic                         busy;
   logic                         axis_n;
   logic                         axis_oe;
   logic                         interp_n;
   logic                         interp_oe;
   logic [15:0]                  en_m [4];
   logic [15:0]                  st_m [4];
   logic                         lo_en;
   logic                         hi_en;
   logic                         pend_m;
   logic [3:0]                   pb_m;
   logic [31:0]                  lfsr_q = 32'hb2e8_4dd1;
   int                           error_cnt = 0;
   int                           total_checks = 0;

   aicirq_host_model host (.mclk_i(mclk_i), .rdata_i(rdata), .read_strobe_n_o(rd_n),
      .write_strobe_n_o(wr_n), .addr_o(addr), .be_o(be), .axis_o(axis), .wdata_o(wdata));

   aicirq_top uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .read_strobe_n_i(rd_n),
      .write_strobe_n_i(wr_n), .host_addr_i(addr), .host_be_i(be), .host_axis_i(axis),
      .host_wdata_i(wdata), .axis_factor_i(factor), .prebuf_count_i(prebuf),
      .cont_interp_busy_i(busy), .host_rdata_o(rdata), .axis_irq_n_o(axis_n),
      .axis_irq_oe_o(axis_oe), .interp_irq_n_o(interp_n), .interp_irq_oe_o(interp_oe));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[15:0];
   endfunction : rnd

   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic chk_irq();
      logic a;
      a = 1'b0;
      for (int g = 0; g < 4; g++) a |= |st_m[g];
      check("axis_irq_oe", {15'h0000, a}, {15'h0000, axis_oe});
      check("axis_irq_n", 16'h0000, {15'h0000, axis_n});
      check("interp_irq_oe", {15'h0000, pend_m}, {15'h0000, interp_oe});
      check("interp_irq_n", 16'h0000, {15'h0000, interp_n});
   endtask : chk_irq

   task automatic set_en(input int g, input logic [1:0] b, input logic [15:0] d);
      logic [15:0] q;
      host.access(1'b0, `AICIRQ_ADDR_IRQ_ENABLE, 2'(g), b, d, rnd() % 3, q);
      if (b[0]) en_m[g][7:0] = d[7:0];
      if (b[1]) en_m[g][15:8] = d[15:8];
   endtask : set_en

   task automatic rd_st(input int g, input logic [1:0] b);
      logic [15:0] q;
      logic [15:0] m;
      m = {{8{b[1]}}, {8{b[0]}}};
      host.access(1'b1, `AICIRQ_ADDR_IRQ_STATUS, 2'(g), b, 16'h0000, rnd() % 3, q);
      check("irq_status", st_m[g] & m, q);
      st_m[g] &= ~m;
      chk_irq();
   endtask : rd_st

   // Event timed to land on the edge at which the read clears
   task automatic rd_race(input int g, input logic [15:0] bits);
      logic [15:0] q;
      fork
         host.access(1'b1, `AICIRQ_ADDR_IRQ_STATUS, 2'(g), 2'b11, 16'h0000, 0, q);
         begin
            repeat (9) @(posedge mclk_i);
            factor[g*16 +: 16] <= bits;
            @(posedge mclk_i);
            factor[g*16 +: 16] <= 16'h0000;
         end
      join
      check("irq_status", st_m[g], q);
      st_m[g] = bits & en_m[g];
      chk_irq();
   endtask : rd_race

   task automatic fire(input int g, input logic [15:0] bits);
      factor[g*16 +: 16] <= bits;
      @(posedge mclk_i);
      factor[g*16 +: 16] <= 16'h0000;
      st_m[g] |= bits & en_m[g];
      repeat (3) @(posedge mclk_i);
      chk_irq();
   endtask : fire

   task automatic cmd(input logic [7:0] code);
      logic [15:0] q;
      host.access(1'b0, `AICIRQ_ADDR_CMD, 2'b00, 2'b11, {8'h00, code}, 0, q);
      if (code == `AICIRQ_CMD_INTERP_CLR || code[7:4] == 4'h3) pend_m = 1'b0;
      repeat (2) @(posedge mclk_i);
      chk_irq();
   endtask : cmd

   task automatic mode(input logic lo, input logic hi);
      logic [15:0] q;
      host.access(1'b0, `AICIRQ_ADDR_DATA, 2'b00, 2'b11, {hi, lo, 14'h0000}, 0, q);
      cmd(`AICIRQ_CMD_INTERP_MODE);
      lo_en = lo;
      hi_en = hi;
   endtask : mode

   task automatic pb(input logic [3:0] v);
      prebuf <= v;
      if ((pb_m == 4'h4 && v == 4'h3 && lo_en) || (pb_m == 4'h8 && v == 4'h7 && hi_en))
         pend_m = 1'b1;
      pb_m = v;
      repeat (4) @(posedge mclk_i);
      chk_irq();
   endtask : pb

   task automatic final_report();
      if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report

   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   initial begin
      #400_000;
      error_cnt++;
      final_report();
   end

   initial begin
      logic [15:0] q0;
      rstn_i = 1'b0;
      factor = 64'h0000_0000_0000_0000;
      prebuf = 4'h0;
      busy = 1'b1;
      {pb_m, lo_en, hi_en, pend_m} = 7'h00;
      for (int g = 0; g < 4; g++) {en_m[g], st_m[g]} = 32'h0000_0000;
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk_irq();
      for (int g = 0; g < 4; g++) begin
         fire(g, 16'hffff);
         rd_st(g, 2'b11);
      end
      for (int k = 0; k < 16; k++) begin
         set_en(k % 4, 2'b11, 16'h0001 << k);
         fire(k % 4, 16'hffff);
         rd_st(k % 4, 2'b11);
      end
      for (int n = 0; n < 12; n++) begin
         set_en(n % 4, 2'b11, rnd());
         fire(n % 4, rnd());
         fire(n % 4, rnd());
         rd_st(n % 4, 2'b11);
         rd_st(n % 4, 2'b11);
      end
      set_en(1, 2'b01, 16'h00a5);
      set_en(1, 2'b10, 16'h5a00);
      fire(1, 16'hffff);
      rd_st(1, 2'b01);
      rd_st(1, 2'b10);
      // Shared line stays low until every axis has been read
      set_en(2, 2'b11, 16'hffff);
      fire(1, 16'h0101);
      fire(2, 16'h8000);
      rd_st(1, 2'b11);
      rd_st(2, 2'b11);
      // A read of another register reads zero and leaves the status pending
      fire(2, 16'h00f0);
      host.access(1'b1, `AICIRQ_ADDR_DATA, 2'd2, 2'b11, 16'h0000, 0, q0);
      check("host_rdata", 16'h0000, q0);
      chk_irq();
      rd_race(2, 16'h0f00);
      rd_st(2, 2'b11);
      pb(4'h8); pb(4'h7); pb(4'h4); pb(4'h3);
      mode(1'b1, 1'b1);
      pb(4'h4); pb(4'h3);
      cmd(`AICIRQ_CMD_INTERP_CLR);
      pb(4'h8); pb(4'h7);
      pb(4'h4); pb(4'h3);
      cmd(8'h35);
      pb(4'h4); pb(4'h3);
      busy <= 1'b0;
      pend_m = 1'b0;
      repeat (4) @(posedge mclk_i);
      chk_irq();
      busy <= 1'b1;
      mode(1'b0, 1'b1);
      pb(4'h4); pb(4'h3); pb(4'h8); pb(4'h7);
      cmd(`AICIRQ_CMD_SEG_LAST);
      mode(1'b1, 1'b0);
      pb(4'h8); pb(4'h7); pb(4'h4); pb(4'h3);
      cmd(`AICIRQ_CMD_SEG_FIRST);
      final_report();
   end
endmodule : axis_and_interp_irq_logic_tb
`default_nettype wire
